// [src/cdc_clock_divider_defines.vh]
// Constants for the clock divider and doubled-clock duty programming block.
`ifndef CDC_CLOCK_DIVIDER_DEFINES_VH
`define CDC_CLOCK_DIVIDER_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets on the three-bit address.
// ----------------------------------------------------------------------------
`define CDC_OFS_INPUT_DIVIDER_CTRL    3'h0
`define CDC_OFS_FEEDBACK_DIVIDER_CTRL 3'h1
`define CDC_OFS_OUTPUT_DIVIDER_CTRL   3'h2
`define CDC_OFS_DOUBLED_DUTY_CTRL     3'h3

// ----------------------------------------------------------------------------
// Divider register fields.
// ----------------------------------------------------------------------------
`define CDC_DIV_VALUE_MSB 3
`define CDC_DIV_VALUE_LSB 0
`define CDC_DIV_RESET_BIT 7

// Ratio modulus for values above the top ratio.
`define CDC_DIV_MODULUS 4'h8

// Value that selects the bypass path.
`define CDC_DIV_BYPASS_VALUE 4'h0

// ----------------------------------------------------------------------------
// Doubled-clock duty register fields.
// ----------------------------------------------------------------------------
`define CDC_DUTY_FIRST_FINE_MSB 2
`define CDC_DUTY_FIRST_FINE_LSB 0
`define CDC_DUTY_SECOND_FINE_MSB 5
`define CDC_DUTY_SECOND_FINE_LSB 3
`define CDC_DUTY_FIRST_RANGE_BIT 6
`define CDC_DUTY_SECOND_RANGE_BIT 7

// Number of 6.25 percent steps that make up 50 percent.
`define CDC_DUTY_HALF_STEPS 5'h08

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define CDC_RST_DIVIDER_CTRL 8'h00
`define CDC_RST_DUTY_CTRL    8'h00
`define CDC_READ_UNMAPPED    8'h00

`endif

// [src/cdc_divider.v]
// One programmable clock divider with its own input synchroniser and bypass path.
`timescale 1ns/10ps
`default_nettype none
`include "cdc_clock_divider_defines.vh"

module cdc_divider (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Clock to divide, asynchronous to clk.
  input wire src_pin,
  // Programmed four-bit value.
  input wire [3:0] value,
  // Divided or bypassed clock.
  output reg clk_out
);

  reg src_s1;
  reg src_s2;
  reg src_d;
  reg div_q;
  reg [3:0] cnt;
  wire [3:0] ratio;
  wire bypass;
  wire rise;
  wire fall;

  // Two-stage synchroniser; only the second stage is looked at.
  always @(posedge clk) begin
    if (rst) begin
      src_s1 <= 1'b0;
      src_s2 <= 1'b0;
      src_d <= 1'b0;
    end else begin
      src_s1 <= src_pin;
      src_s2 <= src_s1;
      src_d <= src_s2;
    end
  end

  assign rise = src_s2 & ~src_d;
  assign fall = ~src_s2 & src_d;

  // Values above the top ratio fold back modulo eight; eight itself stays eight.
  assign ratio = (value > `CDC_DIV_MODULUS) ? (value - `CDC_DIV_MODULUS) : value;
  assign bypass = (value == `CDC_DIV_BYPASS_VALUE);

  // Output is high for the first source high phase of every group of ratio periods.
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
      div_q <= 1'b0;
    end else if (rise) begin
      div_q <= (cnt == 4'h0);
      if (cnt >= ratio - 4'h1) begin
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else if (fall) begin
      div_q <= 1'b0;
    end
  end

  // Bypass takes the synchronised source one stage earlier than the divider path.
  always @(posedge clk) begin
    if (rst) begin
      clk_out <= 1'b0;
    end else if (bypass) begin
      clk_out <= src_s2;
    end else begin
      clk_out <= div_q;
    end
  end

endmodule // cdc_divider
`default_nettype wire

// [src/cdc_clock_divider.v]
// Register interface, three clock dividers and doubled-clock duty decode.
`timescale 1ns/10ps
`default_nettype none
`include "cdc_clock_divider_defines.vh"

// ----------------------------------------------------------------------------
// Top module.
// ----------------------------------------------------------------------------

// Summary of operation
// - Input clock divided by value; zero bypasses.
// - Values above eight use modulo eight.
// - Bypass path shorter than divide by one.
// - Feedback clock divided by value; zero bypasses.
// - Delay line clock divided; zero bypasses.
// - Reset bit holds divider at default.
// - Global reset on dividers gated by ignore bit.
// - Duty means fraction of period clock high.
// - First half duty from bit6 and fine bits.
// - Second half duty from bit7 and bits5:3.
// - Bit 6 picks first period range.
// - Bit 7 picks second period range.
// - Ignore bit set blocks global reset.
// - Duty settings apply only in DLL mode with 2x.
// - Read data driven while read strobe high.
// - Write captured on strobe rise, never both.
module cdc_clock_divider (
  // System clock and reset.
  input wire SYS_CLK,
  input wire RST,
  // Global set/reset from the chip, active low, asynchronous.
  input wire GLOBAL_SET_RESET_N,
  // Control register bit that makes the global reset have no effect.
  input wire GLOBAL_RESET_IGNORE,
  // Mode register state: DLL mode and 2x output selection.
  input wire DLL_MODE,
  input wire MODE_2X,
  // Register port from fabric logic, asynchronous.
  input wire [2:0] ADDR,
  input wire [7:0] WDATA,
  input wire READ_STROBE,
  input wire WRITE_STROBE,
  // Read data and its output enable, low while driving.
  output reg [7:0] RDATA,
  output reg RDATA_OE_N,
  // Clocks to divide.
  input wire INPUT_CLK,
  input wire FEEDBACK_CLK,
  input wire DELAY_LINE_CLK,
  // Divided clocks.
  output wire INPUT_DIV_CLK,
  output wire FEEDBACK_DIV_CLK,
  output wire OUTPUT_DIV_CLK,
  // Doubled-clock duty decode in 6.25 percent steps.
  output reg [4:0] DUTY_FIRST_STEPS,
  output reg [4:0] DUTY_SECOND_STEPS,
  output reg DUTY_ACTIVE
);

  // --------------------------------------------------------------------------
  // Synchronisers.
  // --------------------------------------------------------------------------

  reg re_s1;
  reg re_s2;
  reg we_s1;
  reg we_s2;
  reg we_d;
  reg gsr_n_s1;
  reg gsr_n_s2;
  reg ign_s1;
  reg ign_s2;
  reg mode_dll_s1;
  reg mode_dll_s2;
  reg mode_2x_s1;
  reg mode_2x_s2;
  reg [2:0] addr_s1;
  reg [2:0] addr_s2;
  reg [7:0] wdata_s1;
  reg [7:0] wdata_s2;

  // Every asynchronous input passes two flops. Address and data are stable
  // around the strobe, so the bus synchronisers settle before the strobe edge
  // is seen; a fabric that changes them with the strobe would tear a word.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      re_s1 <= 1'b0;
      re_s2 <= 1'b0;
      we_s1 <= 1'b0;
      we_s2 <= 1'b0;
      we_d <= 1'b0;
      gsr_n_s1 <= 1'b1;
      gsr_n_s2 <= 1'b1;
      ign_s1 <= 1'b0;
      ign_s2 <= 1'b0;
      mode_dll_s1 <= 1'b0;
      mode_dll_s2 <= 1'b0;
      mode_2x_s1 <= 1'b0;
      mode_2x_s2 <= 1'b0;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
      wdata_s1 <= 8'h00;
      wdata_s2 <= 8'h00;
    end else begin
      re_s1 <= READ_STROBE;
      re_s2 <= re_s1;
      we_s1 <= WRITE_STROBE;
      we_s2 <= we_s1;
      we_d <= we_s2;
      gsr_n_s1 <= GLOBAL_SET_RESET_N;
      gsr_n_s2 <= gsr_n_s1;
      ign_s1 <= GLOBAL_RESET_IGNORE;
      ign_s2 <= ign_s1;
      mode_dll_s1 <= DLL_MODE;
      mode_dll_s2 <= mode_dll_s1;
      mode_2x_s1 <= MODE_2X;
      mode_2x_s2 <= mode_2x_s1;
      addr_s1 <= ADDR;
      addr_s2 <= addr_s1;
      wdata_s1 <= WDATA;
      wdata_s2 <= wdata_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Global reset qualification.
  // --------------------------------------------------------------------------

  // The global reset reaches the dividers only while the ignore bit is clear,
  // so a clock sent off chip keeps running through a fabric reset.
  wire gsr_hit;
  assign gsr_hit = ~gsr_n_s2 & ~ign_s2;

  // --------------------------------------------------------------------------
  // Write decode.
  // --------------------------------------------------------------------------

  // A write is the rising edge of the write strobe. If the read strobe is also
  // high the access is illegal and the write is dropped rather than guessed.
  wire wr_fire;
  assign wr_fire = we_s2 & ~we_d & ~re_s2;

  // --------------------------------------------------------------------------
  // Control registers.
  // --------------------------------------------------------------------------

  reg [7:0] input_divider_ctrl;
  reg [7:0] feedback_divider_ctrl;
  reg [7:0] output_divider_ctrl;
  reg [7:0] doubled_clock_duty_ctrl;
  reg [7:0] next_input_divider_ctrl;
  reg [7:0] next_feedback_divider_ctrl;
  reg [7:0] next_output_divider_ctrl;

  // Next value of a divider register from a write. Reserved bits are dropped,
  // and a set reset bit forces the value field back to bypass.
  function [7:0] div_write;
    input [7:0] data;
    begin
      div_write = `CDC_RST_DIVIDER_CTRL;
      div_write[`CDC_DIV_RESET_BIT] = data[`CDC_DIV_RESET_BIT];
      if (!data[`CDC_DIV_RESET_BIT]) begin
        div_write[`CDC_DIV_VALUE_MSB:`CDC_DIV_VALUE_LSB] = data[`CDC_DIV_VALUE_MSB:`CDC_DIV_VALUE_LSB];
      end
    end
  endfunction

  // Divider register next values; a held reset bit keeps the field cleared.
  always @* begin
    next_input_divider_ctrl = input_divider_ctrl;
    next_feedback_divider_ctrl = feedback_divider_ctrl;
    next_output_divider_ctrl = output_divider_ctrl;
    if (wr_fire && addr_s2 == `CDC_OFS_INPUT_DIVIDER_CTRL) begin
      next_input_divider_ctrl = div_write(wdata_s2);
    end
    if (wr_fire && addr_s2 == `CDC_OFS_FEEDBACK_DIVIDER_CTRL) begin
      next_feedback_divider_ctrl = div_write(wdata_s2);
    end
    if (wr_fire && addr_s2 == `CDC_OFS_OUTPUT_DIVIDER_CTRL) begin
      next_output_divider_ctrl = div_write(wdata_s2);
    end
  end

  // Divider registers; the qualified global reset returns them to default.
  always @(posedge SYS_CLK) begin
    if (RST || gsr_hit) begin
      input_divider_ctrl <= `CDC_RST_DIVIDER_CTRL;
      feedback_divider_ctrl <= `CDC_RST_DIVIDER_CTRL;
      output_divider_ctrl <= `CDC_RST_DIVIDER_CTRL;
    end else begin
      input_divider_ctrl <= next_input_divider_ctrl;
      feedback_divider_ctrl <= next_feedback_divider_ctrl;
      output_divider_ctrl <= next_output_divider_ctrl;
    end
  end

  // Duty register; all eight bits are meaningful, the global reset spares it.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      doubled_clock_duty_ctrl <= `CDC_RST_DUTY_CTRL;
    end else if (wr_fire && addr_s2 == `CDC_OFS_DOUBLED_DUTY_CTRL) begin
      doubled_clock_duty_ctrl <= wdata_s2;
    end
  end

  // --------------------------------------------------------------------------
  // Read port.
  // --------------------------------------------------------------------------

  reg [7:0] next_rdata;

  // Read mux; the address may move while the strobe stays high.
  always @* begin
    case (addr_s2)
      `CDC_OFS_INPUT_DIVIDER_CTRL: begin
        next_rdata = input_divider_ctrl;
      end
      `CDC_OFS_FEEDBACK_DIVIDER_CTRL: begin
        next_rdata = feedback_divider_ctrl;
      end
      `CDC_OFS_OUTPUT_DIVIDER_CTRL: begin
        next_rdata = output_divider_ctrl;
      end
      `CDC_OFS_DOUBLED_DUTY_CTRL: begin
        next_rdata = doubled_clock_duty_ctrl;
      end
      default: begin
        next_rdata = `CDC_READ_UNMAPPED;
      end
    endcase
  end

  // Data is driven while the strobe is high and released when it falls; the
  // released bus shows zero so that no stale word is left on the output flops.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
      RDATA_OE_N <= 1'b1;
    end else if (re_s2) begin
      RDATA <= next_rdata;
      RDATA_OE_N <= 1'b0;
    end else begin
      RDATA <= 8'h00;
      RDATA_OE_N <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Dividers.
  // --------------------------------------------------------------------------

  wire rst_input_div;
  wire rst_feedback_div;
  wire rst_output_div;

  // A divider is held while its reset bit is one or the global reset hits it.
  assign rst_input_div = RST | gsr_hit | input_divider_ctrl[`CDC_DIV_RESET_BIT];
  assign rst_feedback_div = RST | gsr_hit | feedback_divider_ctrl[`CDC_DIV_RESET_BIT];
  assign rst_output_div = RST | gsr_hit | output_divider_ctrl[`CDC_DIV_RESET_BIT];

  // Input clock divider.
  cdc_divider u_input_divider (
    .clk(SYS_CLK),
    .rst(rst_input_div),
    .src_pin(INPUT_CLK),
    .value(input_divider_ctrl[`CDC_DIV_VALUE_MSB:`CDC_DIV_VALUE_LSB]),
    .clk_out(INPUT_DIV_CLK)
  );

  // Feedback clock divider.
  cdc_divider u_feedback_divider (
    .clk(SYS_CLK),
    .rst(rst_feedback_div),
    .src_pin(FEEDBACK_CLK),
    .value(feedback_divider_ctrl[`CDC_DIV_VALUE_MSB:`CDC_DIV_VALUE_LSB]),
    .clk_out(FEEDBACK_DIV_CLK)
  );

  // Delay line output divider feeding the fast clock network.
  cdc_divider u_output_divider (
    .clk(SYS_CLK),
    .rst(rst_output_div),
    .src_pin(DELAY_LINE_CLK),
    .value(output_divider_ctrl[`CDC_DIV_VALUE_MSB:`CDC_DIV_VALUE_LSB]),
    .clk_out(OUTPUT_DIV_CLK)
  );

  // --------------------------------------------------------------------------
  // Doubled-clock duty decode.
  // --------------------------------------------------------------------------

  wire [4:0] first_fine;
  wire [4:0] second_fine;
  wire [4:0] first_base;
  wire [4:0] second_base;
  wire duty_apply;

  // Steps count high time in sixteenths of the period: range bit gives half,
  // fine field plus one gives the rest.
  assign first_fine = {2'b00, doubled_clock_duty_ctrl[`CDC_DUTY_FIRST_FINE_MSB:`CDC_DUTY_FIRST_FINE_LSB]} + 5'h01;
  assign second_fine = {2'b00, doubled_clock_duty_ctrl[`CDC_DUTY_SECOND_FINE_MSB:`CDC_DUTY_SECOND_FINE_LSB]} + 5'h01;
  assign first_base = doubled_clock_duty_ctrl[`CDC_DUTY_FIRST_RANGE_BIT] ? `CDC_DUTY_HALF_STEPS : 5'h00;
  assign second_base = doubled_clock_duty_ctrl[`CDC_DUTY_SECOND_RANGE_BIT] ? `CDC_DUTY_HALF_STEPS : 5'h00;

  // The settings take effect only in DLL mode with the doubled output chosen.
  assign duty_apply = mode_dll_s2 & mode_2x_s2;

  // Outside 2x mode both halves report an even 50 percent high time.
  always @(posedge SYS_CLK) begin
    if (RST) begin
      DUTY_FIRST_STEPS <= `CDC_DUTY_HALF_STEPS;
      DUTY_SECOND_STEPS <= `CDC_DUTY_HALF_STEPS;
      DUTY_ACTIVE <= 1'b0;
    end else if (duty_apply) begin
      DUTY_FIRST_STEPS <= first_base + first_fine;
      DUTY_SECOND_STEPS <= second_base + second_fine;
      DUTY_ACTIVE <= 1'b1;
    end else begin
      DUTY_FIRST_STEPS <= `CDC_DUTY_HALF_STEPS;
      DUTY_SECOND_STEPS <= `CDC_DUTY_HALF_STEPS;
      DUTY_ACTIVE <= 1'b0;
    end
  end

endmodule // cdc_clock_divider
`default_nettype wire

// [bench/cdc_clock_divider_properties.sv]
// Port-level checker for the divider and duty programming block.
`timescale 1ns/10ps
`default_nettype none
module cdc_clock_divider_properties (
  // Clock and reset.
  input wire SYS_CLK,
  input wire RST,
  // Watched inputs.
  input wire GLOBAL_SET_RESET_N,
  input wire GLOBAL_RESET_IGNORE,
  input wire DLL_MODE,
  input wire MODE_2X,
  input wire [2:0] ADDR,
  input wire READ_STROBE,
  // Watched outputs.
  input wire [7:0] RDATA,
  input wire RDATA_OE_N,
  input wire INPUT_DIV_CLK,
  input wire FEEDBACK_DIV_CLK,
  input wire OUTPUT_DIV_CLK,
  input wire [4:0] DUTY_FIRST_STEPS,
  input wire [4:0] DUTY_SECOND_STEPS,
  input wire DUTY_ACTIVE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ---------------------------------------------------------------
  // Read port.
  // ---------------------------------------------------------------
  // A released bus shows zero so stale data is never taken for an answer.
  property p_idle_zero;
    RDATA_OE_N |-> RDATA == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read bus not zero when released");
  property p_read_drive;
    READ_STROBE [*4] |-> !RDATA_OE_N;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_read_release;
    !READ_STROBE [*4] |-> RDATA_OE_N;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read bus not released");
  property p_read_hold;
    (READ_STROBE && $stable(ADDR) && GLOBAL_SET_RESET_N) [*5] |-> $stable(RDATA);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved during read");
  // ---------------------------------------------------------------
  // Duty decode and global reset.
  // ---------------------------------------------------------------
  property p_duty_idle;
    !DUTY_ACTIVE |-> DUTY_FIRST_STEPS == 5'h08 && DUTY_SECOND_STEPS == 5'h08;
  endproperty
  a_duty_idle: assert property (p_duty_idle) else $error("duty steps not neutral");
  property p_duty_on;
    (DLL_MODE && MODE_2X) [*5] |-> DUTY_ACTIVE;
  endproperty
  a_duty_on: assert property (p_duty_on) else $error("duty decode not active");
  property p_duty_off;
    (!MODE_2X || !DLL_MODE) [*5] |-> !DUTY_ACTIVE;
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("duty decode active in 1x");
  property p_duty_range;
    DUTY_FIRST_STEPS != 5'h00 && DUTY_FIRST_STEPS <= 5'h10 && DUTY_SECOND_STEPS != 5'h00 && DUTY_SECOND_STEPS <= 5'h10;
  endproperty
  a_duty_range: assert property (p_duty_range) else $error("duty steps out of range");
  // Dividers stay quiet while an unblocked global reset holds them.
  property p_gsr_hold;
    (!GLOBAL_SET_RESET_N && !GLOBAL_RESET_IGNORE) [*8] |-> !INPUT_DIV_CLK && !FEEDBACK_DIV_CLK && !OUTPUT_DIV_CLK;
  endproperty
  a_gsr_hold: assert property (p_gsr_hold) else $error("divider runs in global reset");
endmodule // cdc_clock_divider_properties

bind cdc_clock_divider cdc_clock_divider_properties u_cdc_clock_divider_properties (
  .SYS_CLK(SYS_CLK), .RST(RST), .GLOBAL_SET_RESET_N(GLOBAL_SET_RESET_N),
  .GLOBAL_RESET_IGNORE(GLOBAL_RESET_IGNORE), .DLL_MODE(DLL_MODE), .MODE_2X(MODE_2X),
  .ADDR(ADDR), .READ_STROBE(READ_STROBE), .RDATA(RDATA), .RDATA_OE_N(RDATA_OE_N),
  .INPUT_DIV_CLK(INPUT_DIV_CLK), .FEEDBACK_DIV_CLK(FEEDBACK_DIV_CLK), .OUTPUT_DIV_CLK(OUTPUT_DIV_CLK),
  .DUTY_FIRST_STEPS(DUTY_FIRST_STEPS), .DUTY_SECOND_STEPS(DUTY_SECOND_STEPS), .DUTY_ACTIVE(DUTY_ACTIVE));
`default_nettype wire

// [bench/cdc_fabric_model.sv]
// Fabric-side model that drives the asynchronous register strobes.
`timescale 1ns/10ps
`default_nettype none
module cdc_fabric_model (
  // Clock.
  input wire SYS_CLK,
  // Register port toward the block.
  output logic [2:0] ADDR,
  output logic [7:0] WDATA,
  output logic READ_STROBE,
  output logic WRITE_STROBE,
  input wire [7:0] RDATA,
  input wire RDATA_OE_N
);
  // Quiet bus at time zero.
  initial begin
    ADDR = 3'h0;
    WDATA = 8'h00;
    READ_STROBE = 1'b0;
    WRITE_STROBE = 1'b0;
  end
  // Address and data settle before the strobe rises so the synchroniser sees them whole.
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    repeat (3) @(posedge SYS_CLK);
    WRITE_STROBE <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    WRITE_STROBE <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    WDATA <= ~d;
  endtask
  // Strobe is held until the bus is seen driven, then a few cycles longer so
  // that the answer is seen to stand; reads never overlap writes.
  task automatic read_reg(input logic [2:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge SYS_CLK);
    ADDR <= a;
    READ_STROBE <= 1'b1;
    for (int n = 0; n < 10 && !ok; n++) begin
      @(posedge SYS_CLK);
      if (RDATA_OE_N === 1'b0) begin
        ok = 1'b1;
        d = RDATA;
      end
    end
    repeat (3) @(posedge SYS_CLK);
    READ_STROBE <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
  endtask
endmodule // cdc_fabric_model
`default_nettype wire

// [bench/cdc_clock_divider_tb_top.sv]
// Self-checking bench for the divider and duty programming block.
`timescale 1ns/10ps
`default_nettype none
module cdc_clock_divider_tb_top;
  // ---------------------------------------------------------------
  // Signals.
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic gsr_n = 1'b1;
  logic gsr_ignore = 1'b0;
  logic dll_mode = 1'b0;
  logic mode_2x = 1'b0;
  logic [2:0] src = 3'h0;
  int cnt = 0;
  wire [2:0] addr;
  wire [7:0] wdata;
  wire rd_strobe;
  wire wr_strobe;
  wire [7:0] rdata;
  wire rdata_oe_n;
  wire [2:0] div_out;
  wire [4:0] duty_first;
  wire [4:0] duty_second;
  wire duty_active;
  int bad_count = 0;
  int tests_run = 0;
  int half[3] = '{8, 6, 5};
  logic [7:0] vals[5] = '{8'h00, 8'h03, 8'h08, 8'h09, 8'h0f};
  logic [7:0] duty[4] = '{8'hc9, 8'h00, 8'h47, 8'hb8};
  logic [7:0] v;
  int dly, per, d0, ratio, n;
  // ---------------------------------------------------------------
  // Clocks and instances.
  // ---------------------------------------------------------------
  always #10 sys_clk = ~sys_clk;
  // Source clocks stay far below half the system rate so sampling is exact.
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 3; i++) src[i] <= ((cnt / half[i]) % 2) == 1;
  end
  cdc_clock_divider u_cdc_clock_divider (
    .SYS_CLK(sys_clk), .RST(rst), .GLOBAL_SET_RESET_N(gsr_n), .GLOBAL_RESET_IGNORE(gsr_ignore),
    .DLL_MODE(dll_mode), .MODE_2X(mode_2x), .ADDR(addr), .WDATA(wdata), .READ_STROBE(rd_strobe),
    .WRITE_STROBE(wr_strobe), .RDATA(rdata), .RDATA_OE_N(rdata_oe_n), .INPUT_CLK(src[0]),
    .FEEDBACK_CLK(src[1]), .DELAY_LINE_CLK(src[2]), .INPUT_DIV_CLK(div_out[0]),
    .FEEDBACK_DIV_CLK(div_out[1]), .OUTPUT_DIV_CLK(div_out[2]), .DUTY_FIRST_STEPS(duty_first),
    .DUTY_SECOND_STEPS(duty_second), .DUTY_ACTIVE(duty_active));
  cdc_fabric_model u_cdc_fabric_model (
    .SYS_CLK(sys_clk), .ADDR(addr), .WDATA(wdata), .READ_STROBE(rd_strobe),
    .WRITE_STROBE(wr_strobe), .RDATA(rdata), .RDATA_OE_N(rdata_oe_n));
  // ---------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic fail_hang();
    bad_count++;
    $display("mismatch wait expected event seen none");
    give_verdict();
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    u_cdc_fabric_model.read_reg(a, d, ok);
    if (!ok) fail_hang();
    check("register", d, exp);
  endtask
  function automatic logic sig(input int k);
    return k < 3 ? src[k] : div_out[k - 3];
  endfunction
  task automatic wait_lvl(input int k, input logic lv, inout int c);
    while (sig(k) !== lv) begin
      @(posedge sys_clk);
      c++;
      if (c > 600) fail_hang();
    end
  endtask
  // Delay from a source rise to the divided rise, then one divided period.
  task automatic measure(input int i, output int dl, output int pr);
    int c;
    c = 0;
    wait_lvl(i, 1'b0, c);
    wait_lvl(i, 1'b1, c);
    c = 0;
    wait_lvl(i + 3, 1'b1, c);
    dl = c;
    wait_lvl(i + 3, 1'b0, c);
    wait_lvl(i + 3, 1'b1, c);
    pr = c - dl;
  endtask
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(3'(i), 8'h00);
    check("idle duty", {3'h0, duty_first}, 8'h08);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 5; j++) begin
        v = vals[j];
        ratio = v == 0 ? 1 : (v > 8 ? v - 8 : v);
        u_cdc_fabric_model.write_reg(3'(i), v);
        rd(3'(i), v);
        measure(i, dly, per);
        measure(i, dly, per);
        check("divided period", 8'(per), 8'(ratio * 2 * half[i]));
        if (j == 0) d0 = dly;
        if (j == 3) check("bypass faster", 8'(d0 < dly), 8'h01);
      end
    end
    u_cdc_fabric_model.write_reg(3'h1, 8'h83);
    rd(3'h1, 8'h80);
    n = 0;
    repeat (100) begin
      @(posedge sys_clk);
      n += int'(div_out[1] !== 1'b0);
    end
    check("held divider", 8'(n), 8'h00);
    u_cdc_fabric_model.write_reg(3'h1, 8'h03);
    rd(3'h1, 8'h03);
    measure(1, dly, per);
    measure(1, dly, per);
    check("released period", 8'(per), 8'd36);
    u_cdc_fabric_model.write_reg(3'h2, 8'h75);
    rd(3'h2, 8'h05);
    u_cdc_fabric_model.write_reg(3'h5, 8'h5a);
    rd(3'h5, 8'h00);
    dll_mode <= 1'b1;
    mode_2x <= 1'b1;
    for (int j = 0; j < 4; j++) begin
      v = duty[j];
      u_cdc_fabric_model.write_reg(3'h3, v);
      rd(3'h3, v);
      check("active", {7'h00, duty_active}, 8'h01);
      check("first steps", {3'h0, duty_first}, 8'(v[6] * 8 + v[2:0] + 1));
      check("second steps", {3'h0, duty_second}, 8'(v[7] * 8 + v[5:3] + 1));
    end
    dll_mode <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("pll active", {7'h00, duty_active}, 8'h00);
    check("pll duty", {3'h0, duty_first}, 8'h08);
    dll_mode <= 1'b1;
    mode_2x <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("1x duty", {3'h0, duty_second}, 8'h08);
    u_cdc_fabric_model.write_reg(3'h0, 8'h03);
    gsr_ignore <= 1'b1;
    gsr_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    gsr_n <= 1'b1;
    rd(3'h0, 8'h03);
    gsr_ignore <= 1'b0;
    gsr_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(3'h0, 8'h00);
    rd(3'h3, 8'hb8);
    gsr_n <= 1'b1;
    give_verdict();
  end
endmodule // cdc_clock_divider_tb_top
`default_nettype wire
